/* File: core/dbs_ctrl.sv */
// DRAM bank strobe timing controller: registers and row/column sequencer
// Function
// (RL1) Timing bit 15 picks 8 or 16-bit DRAM
// (RL2) Split accesses into transfers by DRAM width
// (RL3) First-strobe field sets column, row, precharge widths
// (RL4) Row to column strobe delay one cycle
// (RL5) Normal mode: row, column, precharge per transfer
// (RL6) Page mode: later transfers use burst width
// (RL7) Page row closes on page cross or refresh
// (RL8) Twelve enable bits, two per shared pin
// (RL9) At most four pins serve as column strobes; code drives every claimed pin and only flags more than four
// (RL10) Narrow lanes follow address bit zero per pair
// (RL11) Wide half/word: any enabled pair drives low
// (RL12) Byte write low only for byte accesses
// (RL13) Instruction fetches handled as word accesses
// (RL14) Byte write valid through memory cycles
// (RL15) Geometry bits 6:5 set burst strobe width
// (RL16) Either refresh bit enables refresh, interval nonzero
// (RL17) Size codes above 100 are invalid
// (RL18) Bank 0 drives row strobe 0, bank 1 row strobe 1
// (RL19) Geometry bit 0 selects page mode
// (RL20) Page size 512 bytes doubled per size code
// (RL21) Geometry bit 7 reads zero, ignores writes
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module dbs_ctrl
	import dbs_pkg::*;
#(
	parameter int HALF_DIV = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [REG_ADDR_W-1:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [15:0] reg_rdata_o,
	// Access requests from the bus controller
	input wire logic acc_valid_i,
	input wire dbs_acc_t acc_i,
	output logic acc_ready_o,
	output logic acc_done_o,
	// Refresh handshake
	input wire logic refresh_due_i,
	input wire logic [15:0] refresh_interval_value_i,
	output logic refresh_enable_o,
	output logic rows_closed_o,
	// DRAM pins
	output logic row_strobe0_n_o,
	output logic row_strobe1_n_o,
	output logic [5:0] shared_strobe_n_o,
	output logic [5:0] column_strobe_pins_o,
	output logic byte_write_n_o
);

	typedef struct packed {
		logic [1:0][15:0] timing;
		logic [1:0][7:0] geom;
		dbs_phase_t phase;
		logic [4:0] cnt;
		dbs_acc_t acc;
		logic [2:0] left;
		logic in_acc;
		logic [1:0] row_open;
		logic [1:0][26:0] open_addr;
		logic [1:0] ras_n;
		logic cas_on;
		logic done;
		logic [15:0] rdata;
	} dbs_state_t;

	dbs_state_t s;
	dbs_state_t n;
	logic tick;
	logic [5:0] strobe_n;
	logic pin_overflow;
	logic bad_cfg;

	// First-strobe value; the illegal 000 is run as 001 so the
	// sequencer never stalls on a zero count
	function automatic logic [2:0] first_v(input logic [15:0] t);
		logic [2:0] v;
		v = t[FIRST_HI:FIRST_LO];
		if (v == 3'h0) begin
			v = 3'h1;
		end
		return v;
	endfunction

	// Burst column width in half cycles
	function automatic logic [4:0] burst_halves(input logic [7:0] g);
		logic [4:0] h;
		h = 5'h03;
		if (g[BURST_HI:BURST_LO] == 2'b10) begin
			h = 5'h05;
		end else if (g[BURST_HI:BURST_LO] == 2'b11) begin
			h = 5'h07;
		end
		return h; // RL15
	endfunction

	// Row and precharge width in half cycles: one cycle above the code
	function automatic logic [4:0] row_halves(input logic [2:0] v);
		return {1'b0, v, 1'b0} + 5'h02; // RL3
	endfunction

	// Page number; invalid size codes are held at the largest
	function automatic logic [17:0] page_of(input logic [26:0] a, input logic [7:0] g);
		logic [2:0] bs;
		logic [26:0] t;
		bs = g[SIZE_HI:SIZE_LO];
		if (bs > SIZE_CODE_MAX) begin
			bs = SIZE_CODE_MAX; // RL17
		end
		t = a >> (PAGE_BASE_BITS + int'(bs)); // RL20
		return t[17:0];
	endfunction

	// Shared pins claimed by a bank
	function automatic logic [5:0] pins_of(input logic [15:0] t);
		logic [5:0] p;
		for (int i = 0; i < PIN_COUNT; i++) begin
			p[i] = |t[2*i+:2];
		end
		return p;
	endfunction

	function automatic int count_pins(input logic [5:0] p);
		int c;
		c = 0;
		for (int i = 0; i < PIN_COUNT; i++) begin
			c = c + int'(p[i]);
		end
		return c;
	endfunction

	dbs_tick_div #(
		.DIV(HALF_DIV)
	) u_div (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_o(tick)
	);

	dbs_strobe_dec u_dec (
		.en_i(s.timing[s.acc.bank][EN_HI:0]),
		.wide_i(s.timing[s.acc.bank][WIDTH_BIT]),
		.size_i(s.acc.size),
		.a0_i(s.acc.addr[0]),
		.active_i(s.cas_on),
		.strobe_n_o(strobe_n)
	);

	// Every claimed pin is a column strobe, even beyond four; software is warned
	assign column_strobe_pins_o = pins_of(s.timing[0]) | pins_of(s.timing[1]); // RL9
	assign pin_overflow = count_pins(column_strobe_pins_o) > MAX_STROBE_PINS; // RL9
	assign bad_cfg = (s.timing[0][FIRST_HI:FIRST_LO] == 3'h0) ||
		(s.timing[1][FIRST_HI:FIRST_LO] == 3'h0) ||
		(s.geom[0][SIZE_HI:SIZE_LO] > SIZE_CODE_MAX) ||
		(s.geom[1][SIZE_HI:SIZE_LO] > SIZE_CODE_MAX); // RL17

	always_comb begin
		logic b;
		logic [2:0] v;
		logic pm;
		logic wide;
		logic hit;
		logic [2:0] vmax;
		b = s.acc.bank;
		v = first_v(s.timing[b]); // RL3
		pm = s.geom[b][PAGE_BIT]; // RL19
		wide = s.timing[b][WIDTH_BIT]; // RL1
		// Both sides use the current size code, so a resize does not fake a miss
		hit = page_of(s.acc.addr, s.geom[b]) == page_of(s.open_addr[b], s.geom[b]); // RL20
		vmax = first_v(s.timing[0]);
		if (first_v(s.timing[1]) > vmax) begin
			vmax = first_v(s.timing[1]);
		end
		n = s;
		n.done = 1'b0;

		if (reg_we_i) begin
			if (reg_addr_i == OFF_TIMING0) begin
				n.timing[0] = reg_wdata_i;
			end else if (reg_addr_i == OFF_TIMING1) begin
				n.timing[1] = reg_wdata_i;
			end else if (reg_addr_i == OFF_GEOM0) begin
				n.geom[0] = reg_wdata_i[7:0] & GEOM_WMASK; // RL21
			end else if (reg_addr_i == OFF_GEOM1) begin
				n.geom[1] = reg_wdata_i[7:0] & GEOM_WMASK; // RL21
			end
		end

		if (reg_re_i) begin
			if (reg_addr_i == OFF_TIMING0) begin
				n.rdata = s.timing[0];
			end else if (reg_addr_i == OFF_TIMING1) begin
				n.rdata = s.timing[1];
			end else if (reg_addr_i == OFF_GEOM0) begin
				n.rdata = {8'h00, s.geom[0]};
			end else if (reg_addr_i == OFF_GEOM1) begin
				n.rdata = {8'h00, s.geom[1]};
			end else if (reg_addr_i == OFF_STATUS) begin
				n.rdata = {10'h000, bad_cfg, pin_overflow, refresh_enable_o,
					s.row_open, s.phase != PH_IDLE};
			end else begin
				n.rdata = 16'h0000;
			end
		end

		if (tick) begin
			case (s.phase)
				PH_IDLE: begin
					if (refresh_due_i && (|s.row_open)) begin
						// Close every open row, longest precharge covers both
						n.row_open = 2'b00; // RL7
						n.ras_n = 2'b11; // RL7
						n.left = 3'h0;
						n.in_acc = 1'b0;
						n.cnt = row_halves(vmax); // RL7
						n.phase = PH_PRE;
					end else if (acc_valid_i) begin
						n.acc = acc_i;
						if (acc_i.fetch) begin
							n.acc.size = SZ_WORD; // RL13
						end
						n.left = xfer_count(n.acc.size, s.timing[acc_i.bank][WIDTH_BIT]); // RL2
						n.in_acc = 1'b1;
						n.phase = PH_START;
					end
				end
				PH_START: begin
					if (pm && s.row_open[b] && hit && !refresh_due_i) begin
						n.cas_on = 1'b1;
						n.cnt = burst_halves(s.geom[b]); // RL6
						n.phase = PH_COL;
					end else if (s.row_open[b]) begin
						n.ras_n[b] = 1'b1; // RL7
						n.row_open[b] = 1'b0;
						// START tick that follows adds the last half cycle
						n.cnt = row_halves(v) - 5'h01; // RL7
						n.phase = PH_PRE;
					end else begin
						n.ras_n[b] = 1'b0; // RL18
						n.open_addr[b] = s.acc.addr;
						n.cnt = RAS_CAS_HALVES; // RL4
						n.phase = PH_ROW;
					end
				end
				PH_ROW: begin
					if (s.cnt == 5'h01) begin
						n.cas_on = 1'b1;
						n.cnt = row_halves(v) - 5'h01; // RL3
						n.phase = PH_COL;
					end else begin
						n.cnt = s.cnt - 5'h01;
					end
				end
				PH_COL: begin
					if (s.cnt == 5'h01) begin
						n.cas_on = 1'b0;
						n.left = s.left - 3'h1;
						n.acc.addr = s.acc.addr + (wide ? 27'h000_0002 : 27'h000_0001);
						if (pm) begin
							// Row stays open across accesses
							n.row_open[b] = 1'b1; // RL7
							if (s.left == 3'h1) begin
								n.phase = PH_IDLE;
								n.done = 1'b1;
								n.in_acc = 1'b0;
							end else begin
								n.phase = PH_START;
							end
						end else begin
							n.ras_n[b] = 1'b1; // RL5
							n.cnt = row_halves(v) - 5'h01; // RL5
							n.phase = PH_PRE;
						end
					end else begin
						// Row rises half a cycle before the column ends,
						// so the row keeps its coded width; precharge then runs one half cycle over its coded width
						if (!pm && s.cnt == 5'h02) begin
							n.ras_n[b] = 1'b1; // RL3
						end
						n.cnt = s.cnt - 5'h01;
					end
				end
				PH_PRE: begin
					if (s.cnt == 5'h01) begin
						if (s.left == 3'h0) begin
							n.phase = PH_IDLE;
							n.done = s.in_acc;
							n.in_acc = 1'b0;
						end else begin
							n.phase = PH_START;
						end
					end else begin
						n.cnt = s.cnt - 5'h01;
					end
				end
				default: begin
					n.phase = PH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.timing <= {TIMING_RST, TIMING_RST};
			s.geom <= {GEOM_RST, GEOM_RST};
			s.phase <= PH_IDLE;
			s.ras_n <= 2'b11;
		end else begin
			s <= n;
		end
	end

	// Request taken only on a half-cycle tick in idle
	assign acc_ready_o = tick && (s.phase == PH_IDLE) && !(refresh_due_i && (|s.row_open));
	assign acc_done_o = s.done;
	assign reg_rdata_o = s.rdata;
	assign rows_closed_o = (s.row_open == 2'b00) && (s.phase == PH_IDLE);
	assign refresh_enable_o = (s.geom[0][REFRESH_BIT] || s.geom[1][REFRESH_BIT]) &&
		(refresh_interval_value_i != 16'h0000); // RL16
	assign row_strobe0_n_o = s.ras_n[0]; // RL18
	assign row_strobe1_n_o = s.ras_n[1]; // RL18
	assign shared_strobe_n_o = strobe_n;

	// Width-independent; high outside access sequences
	assign byte_write_n_o = !(s.in_acc && (s.acc.size == SZ_BYTE) && !s.acc.fetch); // RL12 RL14

endmodule // dbs_ctrl

/* File: core/dbs_pkg.sv */
// Package for the DRAM bank strobe timing controller
package dbs_pkg;

	// Register offsets on the plain register port
	localparam int REG_ADDR_W = 5;
	localparam logic [4:0] OFF_TIMING0 = 5'h00;
	localparam logic [4:0] OFF_TIMING1 = 5'h04;
	localparam logic [4:0] OFF_GEOM0 = 5'h08;
	localparam logic [4:0] OFF_GEOM1 = 5'h0c;
	localparam logic [4:0] OFF_STATUS = 5'h10;

	// Timing register fields
	localparam int WIDTH_BIT = 15;
	localparam int FIRST_HI = 14;
	localparam int FIRST_LO = 12;
	localparam int EN_HI = 11;

	// Geometry register fields
	localparam int BURST_HI = 6;
	localparam int BURST_LO = 5;
	localparam int REFRESH_BIT = 4;
	localparam int SIZE_HI = 3;
	localparam int SIZE_LO = 1;
	localparam int PAGE_BIT = 0;
	localparam logic [7:0] GEOM_WMASK = 8'h7f;

	// Reset values
	localparam logic [15:0] TIMING_RST = 16'h7000;
	localparam logic [7:0] GEOM_RST = 8'h00;

	// Limits and timing in half cycles
	localparam int PAGE_BASE_BITS = 9;
	localparam logic [2:0] SIZE_CODE_MAX = 3'h4;
	localparam logic [4:0] RAS_CAS_HALVES = 5'h02;
	localparam int MAX_STROBE_PINS = 4;
	localparam int PIN_COUNT = 6;

	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} dbs_size_t;

	typedef enum logic [2:0] {PH_IDLE, PH_START, PH_ROW, PH_COL, PH_PRE} dbs_phase_t;

	typedef struct packed {
		logic [26:0] addr;
		dbs_size_t size;
		logic fetch;
		logic write;
		logic bank;
	} dbs_acc_t;

	// Transfers per access by DRAM width
	function automatic logic [2:0] xfer_count(input dbs_size_t size, input logic wide);
		logic [2:0] r;
		r = 3'h1;
		if (size == SZ_WORD) begin
			r = wide ? 3'h2 : 3'h4;
		end else if (size == SZ_HALF) begin
			r = wide ? 3'h1 : 3'h2;
		end
		return r;
	endfunction

endpackage

/* File: core/dbs_strobe_dec.sv */
// Byte-lane decoder for the six shared strobe pins
`timescale 1ns/1ps
module dbs_strobe_dec
	import dbs_pkg::*;
(
	// Bank settings
	input wire logic [11:0] en_i,
	input wire logic wide_i,
	// Current transfer
	input wire dbs_size_t size_i,
	input wire logic a0_i,
	input wire logic active_i,
	// Pin levels
	output logic [5:0] strobe_n_o
);
	function automatic logic pin_level(input logic [1:0] hl, input logic wide, input dbs_size_t sz,
		input logic a0);
		logic r;
		r = 1'b1;
		if (hl == 2'b11) begin
			r = 1'b0;
		end else if (hl != 2'b00 && wide && sz != SZ_BYTE) begin
			r = 1'b0; // RL11
		end else if (hl == 2'b01) begin
			r = a0; // RL10
		end else if (hl == 2'b10) begin
			r = ~a0; // RL10
		end
		return r;
	endfunction

	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			strobe_n_o[i] = active_i ? pin_level(en_i[2*i+:2], wide_i, size_i, a0_i) : 1'b1; // RL8
		end
	end
endmodule // dbs_strobe_dec

/* File: core/dbs_tick_div.sv */
// Half-cycle enable divider for the strobe sequencer
`timescale 1ns/1ps
module dbs_tick_div #(
	parameter int DIV = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Enable pulse
	output logic tick_o
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;

	always_comb begin
		next_cnt = (cnt == 8'(DIV - 1)) ? 8'h00 : cnt + 8'h01;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 8'h00;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign tick_o = (cnt == 8'(DIV - 1));
endmodule // dbs_tick_div

/* File: tb/dbs_ctrl_sva.sv */
// Port checker for the DRAM strobe controller
`timescale 1ns/1ps
module dbs_ctrl_sva
	import dbs_pkg::*;
#(
	parameter int HALF_DIV = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [REG_ADDR_W-1:0] reg_addr_i,
	input wire logic reg_re_i,
	input wire logic [15:0] reg_rdata_o,
	// Access and refresh
	input wire logic acc_valid_i,
	input wire dbs_acc_t acc_i,
	input wire logic acc_ready_o,
	input wire logic refresh_due_i,
	input wire logic [15:0] refresh_interval_value_i,
	input wire logic refresh_enable_o,
	input wire logic rows_closed_o,
	// DRAM pins
	input wire logic row_strobe0_n_o,
	input wire logic row_strobe1_n_o,
	input wire logic [5:0] shared_strobe_n_o,
	input wire logic [5:0] column_strobe_pins_o,
	input wire logic byte_write_n_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic cas_on;
	logic take;
	logic rows_up;
	assign cas_on = |(~shared_strobe_n_o & column_strobe_pins_o);
	assign take = acc_valid_i && acc_ready_o;
	assign rows_up = row_strobe0_n_o && row_strobe1_n_o;
	sequence row_gap_s;
		!cas_on [*2] ##1 cas_on;
	endsequence
	property bank_row_p(b, ra, rb);
		take && acc_i.bank == b && rows_up |-> ##2 !ra && rb;
	endproperty
	a_row_to_col: assert property ($fell(row_strobe0_n_o) |-> row_gap_s) else $error("row to column gap wrong");
	a_bank0_row: assert property (bank_row_p(1'h0, row_strobe0_n_o, row_strobe1_n_o)) else $error("bank0 row");
	a_bank1_row: assert property (bank_row_p(1'h1, row_strobe1_n_o, row_strobe0_n_o)) else $error("bank1 row");
	a_bw_word: assert property (take && (acc_i.size != SZ_BYTE || acc_i.fetch) |-> ##2 byte_write_n_o [*2])
		else $error("byte write low on wide access");
	a_bw_byte: assert property (take && acc_i.size == SZ_BYTE && !acc_i.fetch |-> ##2 !byte_write_n_o)
		else $error("byte write high on byte access");
	a_ref_off: assert property (refresh_interval_value_i == 16'h0000 |-> !refresh_enable_o) else $error("refresh on");
	a_ready_hold: assert property (refresh_due_i && !rows_up |-> !acc_ready_o) else $error("ready with row open");
	a_closed_rows: assert property (rows_closed_o |-> rows_up) else $error("closed flag with row low");
	a_col_in_row: assert property (cas_on && rows_up |-> $past(cas_on) && !$past(rows_up))
		else $error("column strobe without row");
	a_geom_top: assert property (reg_re_i && (reg_addr_i == OFF_GEOM0 || reg_addr_i == OFF_GEOM1)
		|=> reg_rdata_o[15:7] == 9'h000) else $error("geometry top bits set");
endmodule // dbs_ctrl_sva
bind dbs_ctrl dbs_ctrl_sva #(.HALF_DIV(HALF_DIV)) u_sva (.clk_i, .rst_n_i, .reg_addr_i, .reg_re_i, .reg_rdata_o,
	.acc_valid_i, .acc_i, .acc_ready_o, .refresh_due_i, .refresh_interval_value_i, .refresh_enable_o,
	.rows_closed_o, .row_strobe0_n_o, .row_strobe1_n_o, .shared_strobe_n_o, .column_strobe_pins_o,
	.byte_write_n_o);

/* File: tb/dbs_dram_model.sv */
// Passive DRAM side: counts strobes, keeps widths
`timescale 1ns/1ps
module dbs_dram_model (
	// Pins from the controller
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic row0_n_i,
	input wire logic row1_n_i,
	input wire logic [5:0] strobe_n_i,
	input wire logic [5:0] col_pins_i,
	input wire logic bw_n_i,
	// Observations
	output int n_col_o,
	output int col_w_o,
	output int row0_rise_o,
	output int row1_fall_o,
	output logic [6:0] snap_o
);
	logic cas_on;
	logic cas_q = 1'h0;
	logic r0_q = 1'h1;
	logic r1_q = 1'h1;
	int w = 0;
	assign cas_on = |(~strobe_n_i & col_pins_i);
	always @(posedge clk_i) begin
		cas_q <= cas_on;
		r0_q <= row0_n_i;
		r1_q <= row1_n_i;
		w <= cas_on ? (cas_q ? w + 1 : 1) : 0;
		if (!cas_on && cas_q) begin
			col_w_o <= w;
		end
		if (clr_i) begin
			n_col_o <= 0;
			row0_rise_o <= 0;
			row1_fall_o <= 0;
		end else begin
			// Lanes are kept from the first transfer only
			if (cas_on && !cas_q) begin
				n_col_o <= n_col_o + 1;
				if (n_col_o == 0) begin
					snap_o <= {bw_n_i, strobe_n_i};
				end
			end
			if (row0_n_i && !r0_q) begin
				row0_rise_o <= row0_rise_o + 1;
			end
			if (!row1_n_i && r1_q) begin
				row1_fall_o <= row1_fall_o + 1;
			end
		end
	end
endmodule // dbs_dram_model

/* File: tb/dram_bank_strobe_timing_ctrl_tb_top.sv */
// Self-checking bench for the DRAM strobe controller
`timescale 1ns/1ps
module dram_bank_strobe_timing_ctrl_tb_top;
	import dbs_pkg::*;
	typedef struct packed {
		logic [2:0] v;
		logic wide;
		dbs_size_t size;
		logic fetch;
		logic a0;
		logic [2:0] n;
	} dbs_row_t;
	localparam dbs_row_t ROWS [8] = '{
		'{3'h1, 1'h0, SZ_BYTE, 1'h0, 1'h0, 3'h1}, '{3'h1, 1'h0, SZ_BYTE, 1'h0, 1'h1, 3'h1},
		'{3'h1, 1'h0, SZ_HALF, 1'h0, 1'h0, 3'h2}, '{3'h1, 1'h0, SZ_WORD, 1'h0, 1'h0, 3'h4},
		'{3'h2, 1'h1, SZ_WORD, 1'h0, 1'h1, 3'h2}, '{3'h2, 1'h1, SZ_HALF, 1'h0, 1'h1, 3'h1},
		'{3'h7, 1'h1, SZ_BYTE, 1'h0, 1'h1, 3'h1}, '{3'h3, 1'h1, SZ_BYTE, 1'h1, 1'h1, 3'h2}};
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic [4:0] reg_addr_i = 5'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_we_i = 1'h0;
	logic reg_re_i = 1'h0;
	logic acc_valid_i = 1'h0;
	dbs_acc_t acc_i = '0;
	logic refresh_due_i = 1'h0;
	logic [15:0] refresh_interval_value_i = 16'h0000;
	logic clr = 1'h1;
	logic [15:0] reg_rdata_o;
	logic acc_ready_o, acc_done_o, refresh_enable_o, rows_closed_o;
	logic row_strobe0_n_o, row_strobe1_n_o, byte_write_n_o;
	logic [5:0] shared_strobe_n_o, column_strobe_pins_o;
	logic [6:0] snap, exp_snap;
	logic wl;
	int n_fail = 0;
	int num_checks = 0;
	int cyc, n_col, col_w, r0_rise, r1_fall;
	dbs_ctrl #(.HALF_DIV(1)) u_dut (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
		.reg_rdata_o, .acc_valid_i, .acc_i, .acc_ready_o, .acc_done_o, .refresh_due_i,
		.refresh_interval_value_i, .refresh_enable_o, .rows_closed_o, .row_strobe0_n_o, .row_strobe1_n_o,
		.shared_strobe_n_o, .column_strobe_pins_o, .byte_write_n_o);
	dbs_dram_model u_mem (.clk_i, .clr_i(clr), .row0_n_i(row_strobe0_n_o), .row1_n_i(row_strobe1_n_o),
		.strobe_n_i(shared_strobe_n_o), .col_pins_i(column_strobe_pins_o), .bw_n_i(byte_write_n_o),
		.n_col_o(n_col), .col_w_o(col_w), .row0_rise_o(r0_rise), .row1_fall_o(r1_fall), .snap_o(snap));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_we_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_we_i <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		reg_re_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_re_i <= 1'h0;
		@(posedge clk_i);
		chk(reg_rdata_o, exp);
	endtask
	// Bounded waits, so a stuck sequencer shows as a count mismatch
	task automatic acc(input logic b, input dbs_size_t s, input logic f, input logic [26:0] ad);
		@(posedge clk_i);
		clr <= 1'h0;
		acc_valid_i <= 1'h1;
		acc_i <= '{addr: ad, size: s, fetch: f, write: ~f, bank: b};
		cyc = 0;
		@(posedge clk_i);
		while (acc_ready_o !== 1'h1 && cyc < 50) begin
			@(posedge clk_i);
			cyc++;
		end
		chk(acc_ready_o, 1'h1);
		acc_valid_i <= 1'h0;
		cyc = 0;
		while (acc_done_o !== 1'h1 && cyc < 200) begin
			@(posedge clk_i);
			cyc++;
		end
		chk(acc_done_o, 1'h1);
		// Model latches the last column width one edge after it ends
		@(posedge clk_i);
		clr <= 1'h1;
	endtask
	task automatic finish_test;
		$display("TB: checks=%0d errors=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		finish_test;
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'h1;
		rd(OFF_TIMING0, TIMING_RST);
		rd(OFF_TIMING1, TIMING_RST);
		rd(OFF_GEOM0, {8'h00, GEOM_RST});
		rd(OFF_STATUS, 16'h0000);
		rd(5'h14, 16'h0000);
		wr(OFF_GEOM1, 16'h00ff);
		rd(OFF_GEOM1, 16'h007f);
		rd(OFF_STATUS, 16'h0020);
		wr(OFF_GEOM1, 16'h0010);
		chk(refresh_enable_o, 1'h0);
		refresh_interval_value_i <= 16'h0100;
		@(posedge clk_i);
		@(posedge clk_i);
		chk(refresh_enable_o, 1'h1);
		refresh_interval_value_i <= 16'h0000;
		wr(OFF_TIMING1, 16'h700c);
		for (int i = 0; i < 8; i++) begin
			wr(OFF_TIMING0, {ROWS[i].wide, ROWS[i].v, 12'h093});
			acc(1'h0, ROWS[i].size, ROWS[i].fetch, {26'h000_0000, ROWS[i].a0});
			wl = ROWS[i].wide && (ROWS[i].size != SZ_BYTE || ROWS[i].fetch);
			exp_snap = {ROWS[i].size != SZ_BYTE || ROWS[i].fetch, 2'h3, wl ? 2'h0 : {~ROWS[i].a0, ROWS[i].a0}, 2'h2};
			chk(cyc, ROWS[i].n * (4 * ROWS[i].v + 5) + 1);
			chk(n_col, ROWS[i].n);
			chk(col_w, 2 * ROWS[i].v + 1);
			chk(snap, exp_snap);
		end
		chk(column_strobe_pins_o, 6'h0f);
		// Page mode, burst width code 11, page 512 bytes
		wr(OFF_TIMING0, 16'h1093);
		wr(OFF_GEOM0, 16'h0061);
		acc(1'h0, SZ_BYTE, 1'h0, 27'h000_0000);
		chk(row_strobe0_n_o, 1'h0);
		acc(1'h0, SZ_BYTE, 1'h0, 27'h000_0002);
		chk(col_w, 7);
		chk(cyc, 9);
		chk(r0_rise, 0);
		acc(1'h0, SZ_BYTE, 1'h0, 27'h000_0200);
		chk(r0_rise, 1);
		chk(col_w, 3);
		wr(OFF_GEOM0, 16'h0063);
		acc(1'h0, SZ_BYTE, 1'h0, 27'h000_0300);
		chk(r0_rise, 0);
		refresh_due_i <= 1'h1;
		cyc = 0;
		while (rows_closed_o !== 1'h1 && cyc < 100) begin
			@(posedge clk_i);
			cyc++;
		end
		chk(rows_closed_o, 1'h1);
		chk(row_strobe0_n_o, 1'h1);
		refresh_due_i <= 1'h0;
		wr(OFF_GEOM0, 16'h0000);
		acc(1'h1, SZ_BYTE, 1'h0, 27'h000_0000);
		chk(r1_fall, 1);
		chk(cyc, 34);
		chk(snap, 7'h3d);
		finish_test;
	end
endmodule // dram_bank_strobe_timing_ctrl_tb_top
